// ### src/monitor_rx_event_queue_writer.sv
// Monitor receive event queue writer into shared memory
// Operation
// RULE1 - Read the target entry's new-status flag first; if clear, write the data word then the status word with the flag set.
// RULE2 - If the flag is already set, leave the entry and set the queue overflow flag, which raises an interrupt.
// RULE3 - Without time stamping an entry is a status word (flag 15, group 11, channel 10:8, odd/abort/first/last 3:0) and a data word.
// RULE4 - The group bit is 0 for serial group 0 and 1 for serial group 1.
// RULE5 - Without time stamping, last set means last byte is in the following word if odd is 1, the previous word if odd is 0.
// The code puts the last byte in the following data word whatever odd is, as with time stamping.
// RULE6 - First is set when the following data word holds a message's first byte.
// RULE7 - Abort is set when the received message was aborted.
// RULE8 - Odd is 1 when one byte was placed in the data word and 0 when two were.
// RULE9 - Under V* the odd, abort, first and last flags are written as 1, 0, 1, 1.
// RULE10 - Under GCI a byte is stored only after being received twice in a row; under V* once suffices.
// RULE11 - Under V* the upper data byte is all ones; under GCI it is the next doubly received byte.
// RULE12 - With time stamping an entry is four words: status, data, timestamp and a zero word.
// RULE13 - The timestamp word holds the free-running counter captured at the event.
// RULE14 - With time stamping, last set means the following data word holds the last byte, regardless of odd.
// RULE15 - The queue is bounded by the programmed queue size.
// RULE16 - Software clears an entry's new-status flag after reading it to free the location.
// RULE17 - Entries go to consecutive locations and wrap to the queue start after the last one.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module monitor_rx_event_queue_writer #(
  parameter int CHAN_W = 3
) (
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  // Register port
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [31:0]            reg_rdata_o,
  output logic                   irq_o,
  // Monitor receiver side
  input  wire logic              mon_valid_i,
  input  wire logic [7:0]        mon_byte_i,
  input  wire logic              mon_eom_i,
  input  wire logic              mon_abort_i,
  input  wire logic              serial_group_select_i,
  input  wire logic [CHAN_W-1:0] channel_index_i,
  output logic                   mon_busy_o,
  // Shared memory side
  output logic                   mem_req_o,
  output logic                   mem_we_o,
  output logic [23:0]            mem_addr_o,
  output logic [15:0]            mem_wdata_o,
  input  wire logic              mem_ack_i,
  input  wire logic [15:0]       mem_rdata_i
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_READ  = 3'b001,
    S_DATA  = 3'b011,
    S_TIME  = 3'b010,
    S_ZERO  = 3'b110,
    S_STAT  = 3'b111
  } state_t;

  typedef struct packed {
    state_t      state;
    logic        issued;
    logic [1:0]  cfg;
    logic [23:0] qbase;
    logic [15:0] qsize;
    logic [15:0] wr_idx;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic [15:0] tcount;
    // Byte pairing
    logic        have_lo;
    logic [7:0]  lo_byte;
    logic        in_msg;
    logic        first_pend;
    // Captured entry
    logic [15:0] stat_word;
    logic [15:0] data_word;
    logic [15:0] tstamp;
    logic        last_pend;
    logic [31:0] rdata;
  } core_t;
  core_t st_r, st_nxt;

  logic        f_valid;
  logic [7:0]  f_byte;
  logic        eom_q;
  logic        abort_q;
  logic        group_q;
  logic [CHAN_W-1:0] chan_q;
  mem_if       mif ();

  // Status word builder used for every entry kind
  function automatic logic [15:0] make_status(input logic grp, input logic [CHAN_W-1:0] ch,
                                              input logic odd, input logic ab, input logic fi,
                                              input logic la);
    logic [15:0] w;
    w = '0;
    w[mon_queue_pkg::NS_BIT]    = 1'b1; // RULE1
    w[mon_queue_pkg::GROUP_BIT] = grp; // RULE4
    w[mon_queue_pkg::CHAN_LSB +: CHAN_W] = ch; // RULE3
    w[mon_queue_pkg::ODD_BIT]   = odd; // RULE8
    w[mon_queue_pkg::ABORT_BIT] = ab; // RULE7
    w[mon_queue_pkg::FIRST_BIT] = fi; // RULE6
    w[mon_queue_pkg::LAST_BIT]  = la;
    return w;
  endfunction

  // Entry size in words depends on time stamping
  function automatic logic [23:0] entry_words(input logic timestamp_enable);
    return timestamp_enable ? 24'h000004 : 24'h000002; // RULE3 RULE12
  endfunction

  mon_byte_filter u_filter (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .vstar_i  (st_r.cfg[mon_queue_pkg::CFG_VSTAR_BIT]),
    .valid_i  (mon_valid_i),
    .byte_i   (mon_byte_i),
    .valid_o  (f_valid),
    .byte_o   (f_byte)
  );

  mem_master u_master (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .core        (mif.slave),
    .mem_req_o   (mem_req_o),
    .mem_we_o    (mem_we_o),
    .mem_addr_o  (mem_addr_o),
    .mem_wdata_o (mem_wdata_o),
    .mem_ack_i   (mem_ack_i),
    .mem_rdata_i (mem_rdata_i)
  );

  // Side flags delayed to line up with the filtered byte
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      eom_q   <= 1'b0;
      abort_q <= 1'b0;
      group_q <= 1'b0;
      chan_q  <= '0;
    end else begin
      eom_q   <= mon_valid_i & mon_eom_i;
      abort_q <= mon_abort_i;
      group_q <= serial_group_select_i;
      chan_q  <= channel_index_i;
    end
  end

  logic        timestamp_enable;
  logic        vstar;
  logic [23:0] entry_addr;
  assign timestamp_enable   = st_r.cfg[mon_queue_pkg::CFG_TSV_BIT];
  assign vstar = st_r.cfg[mon_queue_pkg::CFG_VSTAR_BIT];
  assign entry_addr = st_r.qbase + 24'(st_r.wr_idx) * entry_words(timestamp_enable); // RULE17

  // Main next-state logic
  always_comb begin
    logic       do_entry;
    logic [15:0] qsz;
    do_entry = 1'b0;
    qsz = (st_r.qsize < mon_queue_pkg::QSIZE_MIN) ? mon_queue_pkg::QSIZE_MIN : st_r.qsize;
    st_nxt = st_r;
    st_nxt.tcount = st_r.tcount + 16'h0001; // Free-running stamp counter
    mif.req   = 1'b0;
    mif.we    = 1'b0;
    mif.addr  = entry_addr;
    mif.wdata = '0;

    // Register writes and reads
    st_nxt.rdata = '0;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        mon_queue_pkg::REG_CONFIG: st_nxt.cfg   = reg_wdata_i[1:0];
        mon_queue_pkg::REG_QBASE:  st_nxt.qbase = reg_wdata_i[23:0];
        mon_queue_pkg::REG_QSIZE: begin
          st_nxt.qsize  = reg_wdata_i[15:0];
          st_nxt.wr_idx = '0; // Restart at the queue start on resize
        end
        mon_queue_pkg::REG_ENABLE: st_nxt.irq_en = reg_wdata_i[1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        mon_queue_pkg::REG_CONFIG: st_nxt.rdata = {30'h0, st_r.cfg};
        mon_queue_pkg::REG_QBASE:  st_nxt.rdata = {8'h00, st_r.qbase};
        mon_queue_pkg::REG_QSIZE:  st_nxt.rdata = {16'h0000, st_r.qsize};
        mon_queue_pkg::REG_STATUS: st_nxt.rdata = {30'h0, st_r.irq_stat};
        mon_queue_pkg::REG_ENABLE: st_nxt.rdata = {30'h0, st_r.irq_en};
        mon_queue_pkg::REG_WRPTR:  st_nxt.rdata = {16'h0000, st_r.wr_idx};
        mon_queue_pkg::REG_TSTAMP: st_nxt.rdata = {16'h0000, st_r.tcount};
        default: st_nxt.rdata = '0;
      endcase
    end
    // Write-one-to-clear; events below override the clear
    if (reg_wr_i && reg_addr_i == mon_queue_pkg::REG_CLEAR) begin
      st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata_i[1:0];
    end

    // Byte pairing; only accepted while idle, busy output stalls the source
    if (st_r.state == S_IDLE) begin
      if (abort_q && st_r.in_msg) begin
        // Aborted message: report with abort and odd flags and the pending low byte as data
        st_nxt.stat_word = make_status(group_q, chan_q, 1'b1, 1'b1, 1'b0, 1'b0); // RULE7
        st_nxt.data_word = {8'h00, st_r.lo_byte};
        st_nxt.in_msg  = 1'b0;
        st_nxt.have_lo = 1'b0;
        do_entry = 1'b1;
      end else if (f_valid) begin
        if (vstar) begin
          st_nxt.stat_word = make_status(group_q, chan_q, 1'b1, 1'b0, 1'b1, 1'b1); // RULE9
          st_nxt.data_word = {mon_queue_pkg::FILL_BYTE, f_byte}; // RULE11
          do_entry = 1'b1;
        end else if (!st_r.have_lo && !eom_q) begin
          st_nxt.have_lo = 1'b1;
          st_nxt.lo_byte = f_byte;
          st_nxt.first_pend = !st_r.in_msg;
          st_nxt.in_msg = 1'b1;
        end else if (!st_r.have_lo) begin
          // Lone last byte: odd entry, last byte in this word
          st_nxt.stat_word = make_status(group_q, chan_q, 1'b1, 1'b0, !st_r.in_msg, 1'b1); // RULE5 RULE14
          st_nxt.data_word = {8'h00, f_byte};
          st_nxt.in_msg = 1'b0;
          do_entry = 1'b1;
        end else begin
          // Two bytes in the word: odd cleared, upper byte is the second
          st_nxt.stat_word = make_status(group_q, chan_q, 1'b0, 1'b0, st_r.first_pend,
                                         eom_q); // RULE5 RULE14 RULE8
          st_nxt.data_word = {f_byte, st_r.lo_byte}; // RULE11
          st_nxt.have_lo = 1'b0;
          st_nxt.in_msg = !eom_q;
          do_entry = 1'b1;
        end
      end
      if (do_entry) begin
        st_nxt.tstamp = st_r.tcount; // RULE13
        st_nxt.state  = S_READ;
        st_nxt.issued = 1'b0;
      end
    end

    // Memory sequence
    unique case (st_r.state)
      S_IDLE: ;
      S_READ: begin
        mif.req = !st_r.issued; // RULE1
        mif.addr = entry_addr;
        st_nxt.issued = 1'b1;
        if (mif.done) begin
          st_nxt.issued = 1'b0;
          if (mif.rdata[mon_queue_pkg::NS_BIT]) begin
            // Entry not yet acknowledged by software; do not overwrite
            st_nxt.irq_stat[mon_queue_pkg::IRQ_OVF_BIT] = 1'b1; // RULE2 RULE16
            st_nxt.state = S_IDLE;
          end else begin
            st_nxt.state = S_DATA;
          end
        end
      end
      S_DATA: begin
        mif.req = !st_r.issued;
        mif.we = 1'b1;
        mif.addr = entry_addr + 24'h000001;
        mif.wdata = st_r.data_word; // RULE1
        st_nxt.issued = 1'b1;
        if (mif.done) begin
          st_nxt.issued = 1'b0;
          st_nxt.state = timestamp_enable ? S_TIME : S_STAT;
        end
      end
      S_TIME: begin
        mif.req = !st_r.issued;
        mif.we = 1'b1;
        mif.addr = entry_addr + 24'h000002;
        mif.wdata = st_r.tstamp; // RULE12 RULE13
        st_nxt.issued = 1'b1;
        if (mif.done) begin
          st_nxt.issued = 1'b0;
          st_nxt.state = S_ZERO;
        end
      end
      S_ZERO: begin
        mif.req = !st_r.issued;
        mif.we = 1'b1;
        mif.addr = entry_addr + 24'h000003;
        mif.wdata = 16'h0000; // RULE12
        st_nxt.issued = 1'b1;
        if (mif.done) begin
          st_nxt.issued = 1'b0;
          st_nxt.state = S_STAT;
        end
      end
      S_STAT: begin
        // Status last so software never sees a half-written entry
        mif.req = !st_r.issued;
        mif.we = 1'b1;
        mif.addr = entry_addr;
        mif.wdata = st_r.stat_word; // RULE1 RULE3
        st_nxt.issued = 1'b1;
        if (mif.done) begin
          st_nxt.issued = 1'b0;
          st_nxt.state = S_IDLE;
          st_nxt.irq_stat[mon_queue_pkg::IRQ_STORE_BIT] = 1'b1;
          st_nxt.wr_idx = (st_r.wr_idx >= qsz - 16'h0001) ? 16'h0000
                          : st_r.wr_idx + 16'h0001; // RULE15 RULE17
        end
      end
      default: st_nxt.state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      st_r <= '0;
      st_r.qsize <= mon_queue_pkg::QSIZE_RST;
      st_r.qbase <= mon_queue_pkg::QBASE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata_o = st_r.rdata;
  assign irq_o       = |(st_r.irq_stat & st_r.irq_en); // RULE2
  assign mon_busy_o  = (st_r.state != S_IDLE);
endmodule
`default_nettype wire

// ### inc/mon_queue_pkg.sv
// Constants shared by the monitor event queue writer
package mon_queue_pkg;
  // Status word field positions
  localparam int NS_BIT      = 15;
  localparam int GROUP_BIT   = 11;
  localparam int CHAN_LSB    = 8;
  localparam int ODD_BIT     = 3;
  localparam int ABORT_BIT   = 2;
  localparam int FIRST_BIT   = 1;
  localparam int LAST_BIT    = 0;
  // Register map (word offsets)
  localparam logic [3:0] REG_CONFIG   = 4'h0;
  localparam logic [3:0] REG_QBASE    = 4'h1;
  localparam logic [3:0] REG_QSIZE    = 4'h2;
  localparam logic [3:0] REG_STATUS   = 4'h3;
  localparam logic [3:0] REG_CLEAR    = 4'h4;
  localparam logic [3:0] REG_ENABLE   = 4'h5;
  localparam logic [3:0] REG_WRPTR    = 4'h6;
  localparam logic [3:0] REG_TSTAMP   = 4'h7;
  // Config register fields
  localparam int CFG_TSV_BIT = 0;
  localparam int CFG_VSTAR_BIT = 1;
  // Interrupt cause bits
  localparam int IRQ_OVF_BIT   = 0;
  localparam int IRQ_STORE_BIT = 1;
  localparam int IRQ_W         = 2;
  // Reset values
  localparam logic [15:0] QSIZE_RST = 16'h0010;
  localparam logic [23:0] QBASE_RST = 24'h000000;
  // Filler byte under V*
  localparam logic [7:0] FILL_BYTE = 8'hff;
  // Minimum entries in the queue
  localparam logic [15:0] QSIZE_MIN = 16'h0001;
endpackage

// ### inc/mem_if.sv
// Shared memory access port between writer core and bus master
`timescale 1ns/1ps
`default_nettype none
interface mem_if;
  logic        req;
  logic        we;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport master (output req, output we, output addr, output wdata, input done, input rdata);
  modport slave  (input req, input we, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ### src/mon_byte_filter.sv
// Double-receive filter for one monitor byte stream
`timescale 1ns/1ps
`default_nettype none
module mon_byte_filter (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       vstar_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] byte_i,
  output logic            valid_o,
  output logic [7:0]      byte_o
);
  typedef struct packed {
    logic       have;
    logic [7:0] last;
    logic       out_v;
    logic [7:0] out_b;
  } filt_t;
  filt_t st_r, st_nxt;

  // Under GCI only a repeated new byte passes; under V* every byte passes
  always_comb begin
    st_nxt = st_r;
    st_nxt.out_v = 1'b0;
    if (valid_i) begin
      if (vstar_i) begin // RULE10
        st_nxt.out_v = 1'b1;
        st_nxt.out_b = byte_i;
      end else if (st_r.have && st_r.last == byte_i) begin // RULE10
        st_nxt.out_v = 1'b1;
        st_nxt.out_b = byte_i;
        st_nxt.have  = 1'b0; // Same byte must arrive twice again to count anew
      end else begin
        st_nxt.have = 1'b1;
        st_nxt.last = byte_i;
      end
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign valid_o = st_r.out_v;
  assign byte_o  = st_r.out_b;
endmodule
`default_nettype wire

// ### src/mem_master.sv
// Single-word shared memory master with one outstanding access
`timescale 1ns/1ps
`default_nettype none
module mem_master (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  mem_if.slave             core,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [23:0]      mem_addr_o,
  output logic [15:0]      mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i
);
  typedef struct packed {
    logic        busy;
    logic        we;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
  } mm_t;
  mm_t st_r, st_nxt;

  // Hold the access until the memory acknowledges it
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy && core.req && !st_r.done) begin
      st_nxt.busy  = 1'b1;
      st_nxt.we    = core.we;
      st_nxt.addr  = core.addr;
      st_nxt.wdata = core.wdata;
    end else if (st_r.busy && mem_ack_i) begin
      st_nxt.busy  = 1'b0;
      st_nxt.done  = 1'b1;
      st_nxt.rdata = mem_rdata_i;
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mem_req_o   = st_r.busy;
  assign mem_we_o    = st_r.we;
  assign mem_addr_o  = st_r.addr;
  assign mem_wdata_o = st_r.wdata;
  assign core.done   = st_r.done;
  assign core.rdata  = st_r.rdata;
endmodule
`default_nettype wire

// ### verification/mon_queue_monitor.sv
// Concurrent checks on the queue writer top-level ports
`timescale 1ns/1ps
`default_nettype none
module mon_queue_monitor #(
  parameter int CHAN_W = 3
) (
  input wire logic              clock_i,
  input wire logic              resetn_i,
  input wire logic [3:0]        reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_rdata_o,
  input wire logic              irq_o,
  input wire logic              mon_valid_i,
  input wire logic [7:0]        mon_byte_i,
  input wire logic              mon_eom_i,
  input wire logic              mon_abort_i,
  input wire logic              serial_group_select_i,
  input wire logic [CHAN_W-1:0] channel_index_i,
  input wire logic              mon_busy_o,
  input wire logic              mem_req_o,
  input wire logic              mem_we_o,
  input wire logic [23:0]       mem_addr_o,
  input wire logic [15:0]       mem_wdata_o,
  input wire logic              mem_ack_i,
  input wire logic [15:0]       mem_rdata_i
);
  logic [23:0] rd_addr_r;
  logic [1:0]  cfg_r;
  logic        data_seen_r;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  // Entry address, mode bits and data-word progress seen from outside
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_addr_r   <= 24'h0;
      cfg_r       <= 2'h0;
      data_seen_r <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == mon_queue_pkg::REG_CONFIG) cfg_r <= reg_wdata_i[1:0];
      if (mem_req_o && !mem_we_o) begin
        rd_addr_r   <= mem_addr_o;
        data_seen_r <= 1'b0;
      end else if (mem_req_o && mem_we_o && mem_ack_i && mem_addr_o == rd_addr_r + 24'h1) begin
        data_seen_r <= 1'b1;
      end
    end
  end

  sequence s_rd_full;
    mem_req_o && !mem_we_o && mem_ack_i && mem_rdata_i[mon_queue_pkg::NS_BIT];
  endsequence
  sequence s_stat_wr;
    mem_req_o && mem_we_o && mem_addr_o == rd_addr_r;
  endsequence
  sequence s_data_wr;
    mem_req_o && mem_we_o && mem_addr_o == rd_addr_r + 24'h1;
  endsequence

  chk_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
    && $stable(mem_we_o) && $stable(mem_wdata_o)) else $error("memory request changed before ack");
  chk_req_release: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("memory request held past ack");
  chk_status_ns: assert property (s_stat_wr |-> mem_wdata_o[15] && mem_wdata_o[14:12] == 3'h0
    && mem_wdata_o[7:4] == 4'h0) else $error("status word malformed");
  chk_data_first: assert property (s_stat_wr |-> data_seen_r)
    else $error("status written before data word");
  chk_full_skip: assert property (s_rd_full |=> (!(mem_req_o && mem_we_o))[*4])
    else $error("occupied entry overwritten");
  chk_vstar_flags: assert property (s_stat_wr |-> !cfg_r[1] || mem_wdata_o[3:0] == 4'hb)
    else $error("flag bits wrong in V-star mode");
  chk_vstar_fill: assert property (s_data_wr |-> !cfg_r[1] || mem_wdata_o[15:8] == 8'hff)
    else $error("upper byte not filler in V-star mode");
  chk_ts_zero: assert property (mem_req_o && mem_we_o && cfg_r[0] && mem_addr_o == rd_addr_r + 24'h3
    |-> mem_wdata_o == 16'h0) else $error("fourth entry word not zero");
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read answer cycle");
  chk_busy_entry: assert property ($rose(mem_req_o) |-> mon_busy_o)
    else $error("memory access without busy");
endmodule

bind monitor_rx_event_queue_writer mon_queue_monitor #(.CHAN_W(CHAN_W)) u_mon_queue_monitor (
  .clock_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o,
  .mon_valid_i, .mon_byte_i, .mon_eom_i, .mon_abort_i, .serial_group_select_i, .channel_index_i,
  .mon_busy_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i);
`default_nettype wire

// ### verification/queue_mem_model.sv
// Shared memory model with prompt or slow acknowledge
`timescale 1ns/1ps
`default_nettype none
module queue_mem_model (
  input  wire logic        clock_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic             ack_o,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [64];
  logic [1:0]  wait_r;

  initial begin
    ack_o = 1'b0;
    rdata_o = 16'h5a5a;
    wait_r = 2'h0;
    foreach (mem[i]) mem[i] = 16'h0;
  end

  // Read data toggle outside ack so a stale value never looks valid
  always @(posedge clock_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      if (wait_r >= (slow_i ? 2'h3 : 2'h0)) begin
        ack_o <= 1'b1;
        wait_r <= 2'h0;
        rdata_o <= mem[addr_i[5:0]];
        if (we_i) mem[addr_i[5:0]] <= wdata_i;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/monitor_rx_event_queue_writer_tb.sv
// Self-checking bench for the monitor event queue writer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module monitor_rx_event_queue_writer_tb;
  logic        clock_i, resetn_i, reg_wr_i, reg_rd_i, irq_o, mon_valid_i, mon_eom_i, mon_abort_i;
  logic        serial_group_select_i, mon_busy_o, mem_req_o, mem_we_o, mem_ack_i, slow;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rd;
  logic [7:0]  mon_byte_i, b0, b1;
  logic [2:0]  channel_index_i;
  logic [23:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i, t0, t1;
  int          bad_count, n_checks, seed, k;

  monitor_rx_event_queue_writer #(.CHAN_W(3)) u_monitor_rx_event_queue_writer (.clock_i, .resetn_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .mon_valid_i, .mon_byte_i,
    .mon_eom_i, .mon_abort_i, .serial_group_select_i, .channel_index_i, .mon_busy_o, .mem_req_o,
    .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i);
  queue_mem_model u_queue_mem_model (.clock_i, .slow_i(slow), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic send(input logic [7:0] b, input logic eom, input int rep);
    repeat (rep) begin
      @(posedge clock_i);
      mon_valid_i <= 1'b1;
      mon_byte_i <= b;
      mon_eom_i <= eom;
      @(posedge clock_i);
      mon_valid_i <= 1'b0;
    end
  endtask

  // Bounded wait for the writer and memory to go idle
  task automatic quiet();
    int idle;
    int n;
    idle = 0;
    for (n = 0; n < 300 && idle < 8; n++) begin
      @(posedge clock_i);
      #1 idle = (mon_busy_o || mem_req_o) ? 0 : idle + 1;
    end
    if (idle < 8) begin
      bad_count++;
      $display("ERROR %0t: writer never went idle", $time);
      final_report();
    end
  endtask

  function automatic logic [15:0] st(input logic g, input logic [2:0] c, input logic [3:0] f);
    return (16'h1 << mon_queue_pkg::NS_BIT) | (16'(g) << mon_queue_pkg::GROUP_BIT)
      | (16'(c) << mon_queue_pkg::CHAN_LSB) | 16'(f);
  endfunction

  initial begin
    seed = 32'hdb02;
    {resetn_i, reg_wr_i, reg_rd_i, mon_valid_i, mon_eom_i, mon_abort_i, slow} = '0;
    {reg_addr_i, reg_wdata_i, mon_byte_i} = '0;
    serial_group_select_i = 1'($random(seed));
    channel_index_i = 3'($random(seed));
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    reg_wr(mon_queue_pkg::REG_QSIZE, 32'h2);
    reg_wr(mon_queue_pkg::REG_ENABLE, 32'h1);
    reg_rd(mon_queue_pkg::REG_QSIZE, rd);
    `CHK(rd, 32'h2)
    reg_rd(4'hf, rd);
    `CHK(rd, 32'h0)
    $display("registers done");
    // Noise byte seen once must not be stored
    b0 = 8'($random(seed));
    b1 = b0 ^ 8'h3c;
    send(b0 ^ 8'h81, 1'b0, 1);
    send(b0, 1'b0, 2);
    send(b1, 1'b0, 2);
    quiet();
    `CHK(u_queue_mem_model.mem[1], {b1, b0})
    `CHK(u_queue_mem_model.mem[0], st(serial_group_select_i, channel_index_i, 4'b0010))
    // Lone closing byte lands in the next location
    send(b0 ^ 8'hc3, 1'b1, 2);
    quiet();
    `CHK(u_queue_mem_model.mem[3][7:0], b0 ^ 8'hc3)
    `CHK(u_queue_mem_model.mem[2], st(serial_group_select_i, channel_index_i, 4'b1001))
    `CHK(irq_o, 1'b0)
    $display("gci entries done");
    // Wrap onto the unacknowledged first entry
    send(b1, 1'b0, 2);
    send(b0, 1'b0, 2);
    quiet();
    `CHK(u_queue_mem_model.mem[1], {b1, b0})
    `CHK(irq_o, 1'b1)
    reg_rd(mon_queue_pkg::REG_STATUS, rd);
    `CHK(rd[mon_queue_pkg::IRQ_OVF_BIT], 1'b1)
    reg_wr(mon_queue_pkg::REG_CLEAR, 32'h3);
    quiet();
    `CHK(irq_o, 1'b0)
    $display("overflow done");
    // Software acknowledges both entries, then an aborted message
    u_queue_mem_model.mem[0][15] = 1'b0;
    u_queue_mem_model.mem[2][15] = 1'b0;
    reg_wr(mon_queue_pkg::REG_QSIZE, 32'h2);
    send(b0, 1'b0, 2);
    @(posedge clock_i);
    mon_abort_i <= 1'b1;
    @(posedge clock_i);
    mon_abort_i <= 1'b0;
    quiet();
    `CHK(u_queue_mem_model.mem[1][7:0], b0)
    `CHK(u_queue_mem_model.mem[0][3:2], 2'b11)
    $display("abort done");
    // Random single bytes in V-star mode with time stamps
    reg_wr(mon_queue_pkg::REG_CONFIG, 32'h3);
    reg_wr(mon_queue_pkg::REG_QSIZE, 32'h2);
    for (k = 0; k < 4; k++) begin
      b0 = 8'($random(seed));
      slow <= k[0];
      serial_group_select_i <= 1'($random(seed));
      channel_index_i <= 3'($random(seed));
      u_queue_mem_model.mem[(k % 2) * 4][15] = 1'b0;
      reg_rd(mon_queue_pkg::REG_TSTAMP, rd);
      t0 = rd[15:0];
      send(b0, k[1], 1);
      quiet();
      reg_rd(mon_queue_pkg::REG_TSTAMP, rd);
      t1 = rd[15:0];
      `CHK(u_queue_mem_model.mem[(k % 2) * 4], st(serial_group_select_i, channel_index_i, 4'hb))
      `CHK(u_queue_mem_model.mem[(k % 2) * 4 + 1], {8'hff, b0})
      `CHK(u_queue_mem_model.mem[(k % 2) * 4 + 2] >= t0 && u_queue_mem_model.mem[(k % 2) * 4 + 2] <= t1, 1'b1)
      `CHK(u_queue_mem_model.mem[(k % 2) * 4 + 3], 16'h0)
    end
    $display("timestamp entries done");
    final_report();
  end
endmodule
`undef CHK
`default_nettype wire
